//--- design/dic_map.vh
`ifndef DIC_MAP_VH
`define DIC_MAP_VH

// Clock and timing
`define DIC_CLK_HZ 100000000
`define DIC_MS_PER_S 1000
`define DIC_MS_CYCLES (`DIC_CLK_HZ / `DIC_MS_PER_S)
`define DIC_SCAN_MS 3'd5
`define DIC_AC_EXTRA_MS 22'd30

// Widths
`define DIC_NCH 8
`define DIC_VW 9
`define DIC_DW 21
`define DIC_CW 32

// Register byte offsets
`define DIC_OFF_CTRL 8'h00
`define DIC_OFF_ROUTE 8'h04
`define DIC_OFF_PRECEDE 8'h08
`define DIC_OFF_STATE 8'h0c
`define DIC_OFF_EVENT 8'h10
`define DIC_OFF_MASK 8'h14
`define DIC_OFF_CLRCNT 8'h18
`define DIC_OFF_ACTDLY 8'h20
`define DIC_OFF_DROPDLY 8'h40
`define DIC_OFF_THRESH 8'h60
`define DIC_OFF_COUNT 8'h80

// Field positions
`define DIC_CTRL_POL_LSB 0
`define DIC_CTRL_ACM_LSB 8
`define DIC_THR_ACT_LSB 0
`define DIC_THR_REL_LSB 16
`define DIC_STATE_LOGIC_LSB 8
`define DIC_STATE_RELAY_LSB 16
`define DIC_PRE_FIRST_LSB 16
`define DIC_EVT_FALL_LSB 8

// Reset values and the AC release divider
`define DIC_ACT_THR_RST 9'h058
`define DIC_REL_THR_RST 9'h03c
`define DIC_AC_REL_DIV 9'h00a

`endif

//--- design/dic_channel.v
`timescale 1ns/100ps
`default_nettype none
`include "dic_map.vh"

module dic_channel (
  // Clock, reset, timebase
  input wire clk_sys,
  input wire rst,
  input wire msTick,
  input wire scanTick,
  // Field side
  input wire [`DIC_VW-1:0] volt,
  // Settings
  input wire [`DIC_VW-1:0] actThr,
  input wire [`DIC_VW-1:0] relThr,
  input wire acMode,
  input wire polNc,
  input wire [`DIC_DW-1:0] actDly,
  input wire [`DIC_DW-1:0] dropDly,
  input wire cntClr,
  // Results
  output reg state,
  output reg [`DIC_CW-1:0] count
);

  localparam [`DIC_VW-1:0] AC_DIV = `DIC_AC_REL_DIV;

  reg energized;
  reg sampled;
  reg [21:0] dlyCnt;
  wire [`DIC_VW-1:0] relEff;
  wire [21:0] target;
  wire expire;
  wire goUp;

  // AC mode replaces the programmed release level
  assign relEff = acMode ? (actThr / AC_DIV) : relThr;
  // Drop-off gains the AC hold so a half-wave gap does not release
  assign target = state ? ({1'b0, dropDly} + (acMode ? `DIC_AC_EXTRA_MS :
                  22'd0)) : {1'b0, actDly};
  assign expire = (sampled != state) && (dlyCnt >= target);
  assign goUp = expire && sampled;

  // Hysteresis compare and polarity, taken only on the scan tick
  always @(posedge clk_sys) begin
    if (rst) begin
      energized <= 1'b0;
      sampled <= 1'b0;
    end else if (scanTick) begin
      if (volt >= actThr) begin
        energized <= 1'b1;
        sampled <= ~polNc;
      end else if (volt < relEff) begin
        energized <= 1'b0;
        sampled <= polNc;
      end else begin
        sampled <= energized ^ polNc;
      end
    end
  end

  // Qualification timer in 1 ms steps; a bounce back cancels it
  always @(posedge clk_sys) begin
    if (rst) begin
      state <= 1'b0;
      dlyCnt <= 22'd0;
    end else if (sampled == state) begin
      dlyCnt <= 22'd0;
    end else if (expire) begin
      state <= sampled;
      dlyCnt <= 22'd0;
    end else if (msTick) begin
      dlyCnt <= dlyCnt + 22'd1;
    end
  end

  // Activation counter; an edge in the clear cycle still counts
  always @(posedge clk_sys) begin
    if (rst) begin
      count <= {`DIC_CW{1'b0}};
    end else if (cntClr) begin
      count <= goUp ? {{(`DIC_CW-1){1'b0}}, 1'b1} : {`DIC_CW{1'b0}};
    end else if (goUp) begin
      count <= count + {{(`DIC_CW-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

//--- design/dic_conditioner.v
// Behaviour
// - Every channel is sampled once per 5 ms scan tick.
// - Polarity per channel; normally-open reports 1 when energized, default.
// - Rise from 0 to 1 waits a programmable ms activation delay, default 0.
// - Fall from 1 to 0 waits a programmable ms drop-off delay, default 0.
// - AC mode, off by default, adds 30 ms to the drop-off delay.
// - Internal logic sees the filtered state one scan later.
// - A routed relay command follows the logic stage one scan later.
// - Card channels are numbered from one plus the preceding input count.
// - Activation and release thresholds are programmable in 1 V steps.
// - In AC mode the release threshold is a tenth of activation.
// - Each channel counts filtered 0-to-1 edges in 32 bits, clearable.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dic_map.vh"

module dic_conditioner #(
  parameter integer MS_CYCLES = `DIC_MS_CYCLES
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,

  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,

  // Field inputs: 9-bit volt reading per channel, channel 0 lowest
  input wire [`DIC_NCH*`DIC_VW-1:0] chanVolt,

  // Filtered state toward logic and relays
  output wire [`DIC_NCH-1:0] reportedState,
  output reg [`DIC_NCH-1:0] logicState,
  output reg [`DIC_NCH-1:0] relayCmd,

  // Numbering of this card's first channel
  output reg [8:0] firstChannelNum,

  // Interrupt
  output reg irq
);

  // Full-width span first, then cut to the divider width on purpose
  localparam [31:0] MS_SPAN = MS_CYCLES - 1;
  localparam [16:0] MS_LAST = MS_SPAN[16:0];
  localparam [2:0] SCAN_LAST = `DIC_SCAN_MS - 3'd1;

  // Address decode shared by read mux, write path and error answer
  function bankHit;
    input [7:0] addr;
    input [7:0] base;
    begin
      bankHit = (addr[7:5] == base[7:5]);
    end
  endfunction

  function scalarHit;
    input [7:0] addr;
    begin
      scalarHit = (addr[7:5] == 3'b000) && (addr[4:2] != 3'd7) &&
                  (addr[1:0] == 2'b00);
    end
  endfunction

  // A scalar word answers only at its exact, aligned byte address
  function wordHit;
    input [7:0] addr;
    input [7:0] off;
    begin
      wordHit = (addr == off);
    end
  endfunction

  // Timebase
  reg [16:0] msDiv;
  reg [2:0] scanDiv;
  reg msTick;
  reg scanTick;

  // Software settings
  reg [`DIC_NCH-1:0] polNc;
  reg [`DIC_NCH-1:0] acMode;
  reg [`DIC_NCH-1:0] route;
  reg [7:0] precedeCnt;
  reg [`DIC_NCH-1:0] maskRise;
  reg [`DIC_NCH-1:0] maskFall;
  reg [`DIC_DW-1:0] actDly [0:`DIC_NCH-1];
  reg [`DIC_DW-1:0] dropDly [0:`DIC_NCH-1];
  reg [`DIC_VW-1:0] actThr [0:`DIC_NCH-1];
  reg [`DIC_VW-1:0] relThr [0:`DIC_NCH-1];

  // Event status
  reg [`DIC_NCH-1:0] prevState;
  reg [`DIC_NCH-1:0] evtRise;
  reg [`DIC_NCH-1:0] evtFall;
  reg [`DIC_NCH-1:0] next_evtRise;
  reg [`DIC_NCH-1:0] next_evtFall;
  reg evtReadPend;

  // Bus decode
  wire setup;
  wire access;
  wire wrStrobe;
  wire mapped;
  wire [2:0] idx;
  wire [`DIC_NCH-1:0] cntClr;
  wire [`DIC_NCH*`DIC_CW-1:0] countBus;
  wire selCtrl;
  wire selRoute;
  wire selPrecede;
  wire selState;
  wire selEvent;
  wire selMask;
  wire selClrCnt;
  wire selActDly;
  wire selDropDly;
  wire selThresh;
  wire selCount;
  reg [31:0] readMux;
  integer i;

  // APB phase decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wrStrobe = access && pwrite;
  assign idx = paddr[4:2];
  assign mapped = scalarHit(paddr) || bankHit(paddr, `DIC_OFF_ACTDLY) ||
                  bankHit(paddr, `DIC_OFF_DROPDLY) ||
                  bankHit(paddr, `DIC_OFF_THRESH) ||
                  bankHit(paddr, `DIC_OFF_COUNT);

  // Scalar word selects, shared by write path, read mux and event clear
  assign selCtrl = wordHit(paddr, `DIC_OFF_CTRL);
  assign selRoute = wordHit(paddr, `DIC_OFF_ROUTE);
  assign selPrecede = wordHit(paddr, `DIC_OFF_PRECEDE);
  assign selState = wordHit(paddr, `DIC_OFF_STATE);
  assign selEvent = wordHit(paddr, `DIC_OFF_EVENT);
  assign selMask = wordHit(paddr, `DIC_OFF_MASK);
  assign selClrCnt = wordHit(paddr, `DIC_OFF_CLRCNT);

  // Bank selects; the word index within a bank is paddr[4:2]
  assign selActDly = bankHit(paddr, `DIC_OFF_ACTDLY);
  assign selDropDly = bankHit(paddr, `DIC_OFF_DROPDLY);
  assign selThresh = bankHit(paddr, `DIC_OFF_THRESH);
  assign selCount = bankHit(paddr, `DIC_OFF_COUNT);

  // Zero wait state: data is staged in setup, so access always completes
  assign pready = access;

  // Counter clear is a write-one pulse and never stored
  assign cntClr = (wrStrobe && selClrCnt) ?
                  pwdata[`DIC_NCH-1:0] : {`DIC_NCH{1'b0}};

  // 1 ms and 5 ms enables from one divider chain
  always @(posedge clk_sys) begin
    if (rst) begin
      msDiv <= 17'd0;
      scanDiv <= 3'd0;
      msTick <= 1'b0;
      scanTick <= 1'b0;
    end else begin
      msTick <= 1'b0;
      scanTick <= 1'b0;
      if (msDiv == MS_LAST) begin
        msDiv <= 17'd0;
        msTick <= 1'b1;
        if (scanDiv == SCAN_LAST) begin
          scanDiv <= 3'd0;
          scanTick <= 1'b1;
        end else begin
          scanDiv <= scanDiv + 3'd1;
        end
      end else begin
        msDiv <= msDiv + 17'd1;
      end
    end
  end

  // Channel filters
  genvar g;
  generate
    for (g = 0; g < `DIC_NCH; g = g + 1) begin : gChan
      dic_channel uChan (
        .clk_sys(clk_sys),
        .rst(rst),
        .msTick(msTick),
        .scanTick(scanTick),
        .volt(chanVolt[g*`DIC_VW +: `DIC_VW]),
        .actThr(actThr[g]),
        .relThr(relThr[g]),
        .acMode(acMode[g]),
        .polNc(polNc[g]),
        .actDly(actDly[g]),
        .dropDly(dropDly[g]),
        .cntClr(cntClr[g]),
        .state(reportedState[g]),
        .count(countBus[g*`DIC_CW +: `DIC_CW])
      );
    end
  endgenerate

  // Scan pipeline: logic one scan behind the filter, relays one more
  always @(posedge clk_sys) begin
    if (rst) begin
      logicState <= {`DIC_NCH{1'b0}};
      relayCmd <= {`DIC_NCH{1'b0}};
    end else if (scanTick) begin
      logicState <= reportedState;
      relayCmd <= logicState & route;
    end
  end

  // First channel number follows the count of inputs on earlier modules
  always @(posedge clk_sys) begin
    if (rst) begin
      firstChannelNum <= 9'd1;
    end else begin
      firstChannelNum <= {1'b0, precedeCnt} + 9'd1;
    end
  end

  // Software registers; writes land on the access edge only
  always @(posedge clk_sys) begin
    if (rst) begin
      polNc <= {`DIC_NCH{1'b0}};
      acMode <= {`DIC_NCH{1'b0}};
      route <= {`DIC_NCH{1'b0}};
      precedeCnt <= 8'h00;
      maskRise <= {`DIC_NCH{1'b0}};
      maskFall <= {`DIC_NCH{1'b0}};
      for (i = 0; i < `DIC_NCH; i = i + 1) begin
        actDly[i] <= {`DIC_DW{1'b0}};
        dropDly[i] <= {`DIC_DW{1'b0}};
        actThr[i] <= `DIC_ACT_THR_RST;
        relThr[i] <= `DIC_REL_THR_RST;
      end
    end else if (wrStrobe) begin
      if (selCtrl) begin
        polNc <= pwdata[`DIC_CTRL_POL_LSB +: `DIC_NCH];
        acMode <= pwdata[`DIC_CTRL_ACM_LSB +: `DIC_NCH];
      end
      if (selRoute) begin
        route <= pwdata[`DIC_NCH-1:0];
      end
      if (selPrecede) begin
        precedeCnt <= pwdata[7:0];
      end
      if (selMask) begin
        maskRise <= pwdata[`DIC_NCH-1:0];
        maskFall <= pwdata[`DIC_EVT_FALL_LSB +: `DIC_NCH];
      end
      if (selActDly) begin
        actDly[idx] <= pwdata[`DIC_DW-1:0];
      end
      if (selDropDly) begin
        dropDly[idx] <= pwdata[`DIC_DW-1:0];
      end
      if (selThresh) begin
        actThr[idx] <= pwdata[`DIC_THR_ACT_LSB +: `DIC_VW];
        relThr[idx] <= pwdata[`DIC_THR_REL_LSB +: `DIC_VW];
      end
    end
  end

  // Read mux; unmapped words read as zero
  always @* begin
    readMux = 32'h00000000;
    if (selCtrl) begin
      readMux[`DIC_CTRL_POL_LSB +: `DIC_NCH] = polNc;
      readMux[`DIC_CTRL_ACM_LSB +: `DIC_NCH] = acMode;
    end else if (selRoute) begin
      readMux[`DIC_NCH-1:0] = route;
    end else if (selPrecede) begin
      readMux[7:0] = precedeCnt;
      readMux[`DIC_PRE_FIRST_LSB +: 9] = firstChannelNum;
    end else if (selState) begin
      readMux[`DIC_NCH-1:0] = reportedState;
      readMux[`DIC_STATE_LOGIC_LSB +: `DIC_NCH] = logicState;
      readMux[`DIC_STATE_RELAY_LSB +: `DIC_NCH] = relayCmd;
    end else if (selEvent) begin
      readMux[`DIC_NCH-1:0] = evtRise;
      readMux[`DIC_EVT_FALL_LSB +: `DIC_NCH] = evtFall;
    end else if (selMask) begin
      readMux[`DIC_NCH-1:0] = maskRise;
      readMux[`DIC_EVT_FALL_LSB +: `DIC_NCH] = maskFall;
    end else if (selActDly) begin
      readMux[`DIC_DW-1:0] = actDly[idx];
    end else if (selDropDly) begin
      readMux[`DIC_DW-1:0] = dropDly[idx];
    end else if (selThresh) begin
      readMux[`DIC_THR_ACT_LSB +: `DIC_VW] = actThr[idx];
      readMux[`DIC_THR_REL_LSB +: `DIC_VW] = relThr[idx];
    end else if (selCount) begin
      readMux = countBus[idx*`DIC_CW +: `DIC_CW];
    end
  end

  // Stage read data and error in setup so both come from flops
  always @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      evtReadPend <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : readMux;
      pslverr <= !mapped;
      evtReadPend <= !pwrite && selEvent;
    end else if (access) begin
      evtReadPend <= 1'b0;
    end
  end

  // Sticky events; read clears only the bits staged, so new edges survive
  always @* begin
    next_evtRise = evtRise;
    next_evtFall = evtFall;
    if (access && evtReadPend) begin
      next_evtRise = next_evtRise & ~prdata[`DIC_NCH-1:0];
      next_evtFall = next_evtFall & ~prdata[`DIC_EVT_FALL_LSB +: `DIC_NCH];
    end
    next_evtRise = next_evtRise | (reportedState & ~prevState);
    next_evtFall = next_evtFall | (~reportedState & prevState);
  end

  // Event registers and the level interrupt
  always @(posedge clk_sys) begin
    if (rst) begin
      prevState <= {`DIC_NCH{1'b0}};
      evtRise <= {`DIC_NCH{1'b0}};
      evtFall <= {`DIC_NCH{1'b0}};
      irq <= 1'b0;
    end else begin
      prevState <= reportedState;
      evtRise <= next_evtRise;
      evtFall <= next_evtFall;
      irq <= |((next_evtRise & maskRise) | (next_evtFall & maskFall));
    end
  end

endmodule

`default_nettype wire

//--- tb/dic_cond_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dic_cond_chk #(
  parameter integer MS_CYCLES = 4
) (
  // Clock, reset and APB
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Field and results
  input wire logic [71:0] chanVolt,
  input wire logic [7:0] reportedState,
  input wire logic [7:0] logicState,
  input wire logic [7:0] relayCmd,
  input wire logic [8:0] firstChannelNum,
  input wire logic irq
);
  // One scan plus the two-cycle filter pipeline
  localparam int SCAN_MAX = 5 * MS_CYCLES + 2;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_ready_level: assert property (pready == (psel && penable))
    else $error("pready does not follow the access phase");
  a_reset_clear: assert property ($fell(rst) |-> logicState == 8'h00 &&
    relayCmd == 8'h00 && !irq && firstChannelNum == 9'h001)
    else $error("outputs not cleared by reset");
  a_logic_copy: assert property (
    $changed(logicState) |-> logicState == $past(reportedState))
    else $error("logic state is not the previous reported state");
  a_logic_spaced: assert property (
    $changed(logicState) |=> $stable(logicState) [*8])
    else $error("logic state moved between scan ticks");
  a_logic_latency: assert property (
    $changed(reportedState) |-> ##[1:SCAN_MAX] logicState == reportedState)
    else $error("logic state missed one scan");
  a_relay_source: assert property (
    $changed(relayCmd) |-> (relayCmd & ~$past(logicState)) == 8'h00)
    else $error("relay set without logic state");
  a_relay_spaced: assert property (
    $changed(relayCmd) |=> $stable(relayCmd) [*8])
    else $error("relay command moved between scan ticks");
  a_first_number: assert property (
    psel && penable && pwrite && paddr == 8'h08 |-> ##2
    firstChannelNum == {1'b0, $past(pwdata[7:0], 2)} + 9'h001)
    else $error("first channel number wrong");
  a_unmapped_err: assert property (psel && penable && paddr == 8'hfc
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  // Main scenarios reached
  c_irq_rise: cover property ($rose(irq));
  c_relay_move: cover property ($changed(relayCmd));
  c_refused: cover property (psel && penable && pslverr);
endmodule

bind dic_conditioner dic_cond_chk #(.MS_CYCLES(MS_CYCLES)) chk (
  .clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .chanVolt(chanVolt),
  .reportedState(reportedState), .logicState(logicState),
  .relayCmd(relayCmd), .firstChannelNum(firstChannelNum), .irq(irq));
`default_nettype wire

//--- tb/dic_field_model.sv
`timescale 1ns/100ps
`default_nettype none
module dic_field_model (
  // Clock
  input wire logic clk_sys,
  // Contact control from the bench
  input wire logic [7:0] energize,
  input wire logic [8:0] hiVolt,
  // Measured volts toward the conditioner
  output logic [71:0] chanVolt
);
  // Open contacts read 0 V; readings move just after an edge
  always @(posedge clk_sys) begin
    for (int i = 0; i < 8; i++) begin
      chanVolt[9*i +: 9] <= energize[i] ? hiVolt : 9'h000;
    end
  end
endmodule
`default_nettype wire

//--- tb/test_digital_input_conditioner.sv
`timescale 1ns/100ps
`default_nettype none
module test_digital_input_conditioner;
  localparam integer MS = 4;
  logic clk_sys, rst, psel, penable, pwrite, err;
  logic [7:0] paddr, energize;
  logic [31:0] pwdata, rdata;
  logic [8:0] hiVolt;
  wire [71:0] chanVolt;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [7:0] reportedState, logicState, relayCmd;
  wire [8:0] firstChannelNum;
  int fails, num_checks, n;
  // Polarity, energized lines, expected state
  logic [23:0] rows [4] = '{24'h00ffff, 24'hffff00, 24'h0f333c, 24'h000000};

  dic_field_model field (.clk_sys(clk_sys), .energize(energize),
    .hiVolt(hiVolt), .chanVolt(chanVolt));
  dic_conditioner #(.MS_CYCLES(MS)) uut (.clk_sys(clk_sys), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .chanVolt(chanVolt), .reportedState(reportedState),
    .logicState(logicState), .relayCmd(relayCmd),
    .firstChannelNum(firstChannelNum), .irq(irq));

  // Free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits an edge first so back-to-back calls idle once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // No cycle budget here: only the watchdog ends a wait
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task waitc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  // Cycles until a channel shows the wanted level, capped
  task measure(input int ch, input logic v, output int cyc);
    cyc = 0;
    // Look mid-cycle so the edge that flips the state is never raced
    while (reportedState[ch] !== v && cyc < 400) begin
      @(negedge clk_sys);
      cyc++;
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    energize = 8'h00;
    hiVolt = 9'd110;
    fails = 0;
    num_checks = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    apb(0, 8'h00, 0); chk("ctrl", rdata, 32'h0);
    apb(0, 8'h20, 0); chk("actdly", rdata, 32'h0);
    apb(0, 8'h40, 0); chk("dropdly", rdata, 32'h0);
    apb(0, 8'h60, 0); chk("thresh", rdata, 32'h003c0058);
    chk("first", firstChannelNum, 32'h1);
    $display("reset values done");
    apb(1, 8'h04, 32'h0f);
    foreach (rows[i]) begin
      apb(1, 8'h00, {24'h0, rows[i][23:16]});
      energize <= rows[i][15:8];
      waitc(80);
      apb(0, 8'h0c, 0);
      chk("reported", rdata[7:0], rows[i][7:0]);
      chk("logic", rdata[15:8], rows[i][7:0]);
      chk("relay", rdata[23:16], rows[i][7:0] & 8'h0f);
    end
    chk("irqMasked", irq, 32'h0);
    $display("table done");
    hiVolt <= 9'd70;
    energize <= 8'h01;
    waitc(60); chk("below", reportedState[0], 32'h0);
    apb(1, 8'h60, 32'h00280032);
    apb(0, 8'h60, 0); chk("thrRd", rdata, 32'h00280032);
    waitc(60); chk("above", reportedState[0], 32'h1);
    apb(1, 8'h40, 32'h5);
    apb(1, 8'h00, 32'h100);
    hiVolt <= 9'd30;
    waitc(200); chk("acHold", reportedState[0], 32'h1);
    energize <= 8'h00;
    measure(0, 1'b0, n);
    chk("acDrop", n >= 130 && n <= 175, 32'h1);
    apb(1, 8'h00, 32'h0);
    $display("threshold and AC done");
    apb(1, 8'h24, 32'ha);
    apb(1, 8'h14, 32'h2);
    apb(1, 8'h18, 32'hff);
    apb(0, 8'h10, 0);
    hiVolt <= 9'd110;
    energize <= 8'h02;
    waitc(20);
    energize <= 8'h00;
    waitc(100); chk("abandon", reportedState[1], 32'h0);
    energize <= 8'h02;
    measure(1, 1'b1, n);
    chk("actDly", n >= 36 && n <= 70, 32'h1);
    waitc(3); chk("irq", irq, 32'h1);
    apb(0, 8'h10, 0); chk("event", rdata[15:0], 32'h2);
    waitc(2); chk("irqClr", irq, 32'h0);
    apb(0, 8'h84, 0); chk("count", rdata, 32'h1);
    apb(1, 8'h18, 32'h2);
    apb(0, 8'h84, 0); chk("cntClr", rdata, 32'h0);
    $display("delay, counter and interrupt done");
    apb(1, 8'h08, 32'h0b);
    waitc(2); chk("first", firstChannelNum, 32'hc);
    apb(0, 8'h08, 0); chk("preRd", rdata[24:16], 32'hc);
    apb(0, 8'hfc, 0);
    chk("slverr", err, 32'h1);
    chk("unmapped", rdata, 32'h0);
    $display("numbering and refusal done");
    complete_run;
  end

  // Tests need about 1100 cycles; 20000 leaves ample margin
  initial begin
    #200000;
    fails++;
    complete_run;
  end
endmodule
`default_nettype wire
